//--- common/asrc_defines.svh
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH
// Overview of operation
// - Emulate 2^20 interpolation; each output frame takes the nearest interpolated phase.
// - One FIR convolution per output period; 64 taps when not decimating.
// - Output frame arrival found finely by averaging coarse period measurements.
// - Coefficient ROM holds a small subset; coefficients interpolated at second order.
// - When decimating, coefficients are stretched and convolution lengthened by rate ratio.
// - Input samples scaled by output/input ratio and soft-mute gain before storage.
// - Sample RAM holds 512 words per channel, left and right.
// - Write address is input counter plus 16, keeping reads off the write slot.
// - Input-rate counter gives the write address and the servo ramp input.
// - Servo integer part is the RAM start, fractional part the ROM start.
// - When decimating, servo fraction is divided by the input/output ratio.
// - Servo starts in fast mode after reset or rate change, then slow mode.
// - Settling mute flag stays high while the servo is in fast mode.
// - FIR length is 64 taps, or 64 times input/output ratio when decimating.
// - RAM address steps down per tap, ROM up by scaled 2^20; stop on rollover.
// - One multiply-accumulate unit serves both channels.
// - Ratio from comparing output and input counters; held at one when interpolating.
// - Decimation ratio updates only when it moves by more than two input frames per window, or returns to one.
// - Under reset all registers take defaults and all pins stay undriven.
// - After reset the FIFO is zeroed, settle mute set, and outputs enabled.
// - After reset the soft-mute counter starts at full attenuation.
// - Soft mute steps a 12-bit counter once per input frame, 4095 frames full span.
// - Settling mute flag drops as soon as the servo enters slow mode.
`define ASRC_RAM_DEPTH  512
`define ASRC_RAM_LAST   9'h1FF
`define ASRC_WR_OFFSET  9'h010
`define ASRC_RATIO_ONE  10'h040
`define ASRC_RATIO_MAX  10'h1F0
`define ASRC_HYST       10'h002
`define ASRC_WIN_LAST   6'h3F
`define ASRC_RECIP_ONE  17'h10000
`define ASRC_RECIP_NUM  23'h400000
`define ASRC_STEP_ONE   21'h100000
`define ASRC_FRAC_MAX   20'hFFFFF
`define ASRC_CENTER     26'h2000000
`define ASRC_MUTE_FULL  12'hFFF
`define ASRC_K_FAST     5'h02
`define ASRC_K_SLOW     5'h06
`define ASRC_CALM_ERR   25'h0000200
`define ASRC_CALM_LAST  5'h0F
`define ASRC_ROUND      48'sh80000
`endif

//--- common/asrc_pkg.sv
package asrc_pkg;
	typedef enum logic [2:0] {
		ST_CLEAR,
		ST_IDLE,
		ST_LEFT,
		ST_RIGHT,
		ST_DONE
	} asrc_state_t;
endpackage

//--- rtl/asrc_core.sv
`timescale 1ns/1ps
`include "asrc_defines.svh"
module asrc_core (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        clk_link,
	input  wire logic        in_strobe,
	input  wire logic [23:0] in_left,
	input  wire logic [23:0] in_right,
	input  wire logic        out_frame,
	input  wire logic        mute_in,
	output logic      [23:0] out_left,
	output logic      [23:0] out_right,
	output logic             out_valid,
	output logic             settle_mute,
	output logic             pins_oe
);
	import asrc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic int coef_tab(input int i);
		case (i)
			0:       coef_tab = 32'h00009858;
			1:       coef_tab = 32'h000095F4;
			2:       coef_tab = 32'h00008EF9;
			3:       coef_tab = 32'h000083FB;
			4:       coef_tab = 32'h000075DA;
			5:       coef_tab = 32'h000065A5;
			6:       coef_tab = 32'h00005482;
			7:       coef_tab = 32'h00004395;
			8:       coef_tab = 32'h000033CC;
			9:       coef_tab = 32'h000025DF;
			10:      coef_tab = 32'h00001A38;
			11:      coef_tab = 32'h00001100;
			12:      coef_tab = 32'h00000A1E;
			13:      coef_tab = 32'h00000551;
			14:      coef_tab = 32'h0000023D;
			15:      coef_tab = 32'h00000089;
			default: coef_tab = 0;
		endcase
	endfunction

	// half kernel stored every two taps; quadratic fill-in between entries
	function automatic logic signed [17:0] coef_at(input logic [25:0] a);
		logic [25:0] d;
		int          i;
		int          m;
		int          y0;
		int          y1;
		int          y2;
		int          v;
		d  = a[25] ? 26'(a - `ASRC_CENTER) : 26'(`ASRC_CENTER - a);
		i  = int'(d[25:21]);
		m  = int'(d[20:11]);
		y0 = coef_tab(i);
		y1 = coef_tab(i + 1);
		y2 = coef_tab(i + 2);
		v  = y0 + ((m * (y1 - y0)) >>> 10);
		v  = v + ((((m * (m - 1024)) >>> 10) * (y2 - 2 * y1 + y0)) >>> 11);
		return 18'(v);
	endfunction

	function automatic logic [23:0] sat24(input logic signed [47:0] a);
		logic signed [47:0] r;
		r = (a + `ASRC_ROUND) >>> 20;
		if (r > 48'sh7FFFFF)
			return 24'h7FFFFF;
		else if (r < -48'sh800000)
			return 24'h800000;
		else
			return r[23:0];
	endfunction

	function automatic logic [23:0] scale_in(input logic signed [23:0] x,
		input logic [12:0] g, input logic [16:0] r);
		logic signed [55:0] p;
		p = x * $signed({1'b0, g}) * $signed({1'b0, r});
		return 24'(p >>> 28);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link side: frame captured on the source clock, announced by a toggle

	logic [23:0] lk_l_reg;
	logic [23:0] lk_r_reg;
	logic        lk_tog_reg;

	always_ff @(posedge clk_link or negedge arst_n) begin
		if (!arst_n) begin
			lk_l_reg   <= 24'h000000;
			lk_r_reg   <= 24'h000000;
			lk_tog_reg <= 1'b0;
		end else if (in_strobe) begin
			lk_l_reg   <= in_left;
			lk_r_reg   <= in_right;
			lk_tog_reg <= ~lk_tog_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic tog_s1_reg;
	logic tog_s2_reg;
	logic tog_s3_reg;
	logic fr_s1_reg;
	logic fr_s2_reg;
	logic fr_s3_reg;
	logic mu_s1_reg;
	logic mu_s2_reg;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			{tog_s1_reg, tog_s2_reg, tog_s3_reg} <= 3'h0;
			{fr_s1_reg, fr_s2_reg, fr_s3_reg}    <= 3'h0;
			{mu_s1_reg, mu_s2_reg}               <= 2'h0;
		end else begin
			{tog_s1_reg, tog_s2_reg, tog_s3_reg} <= {lk_tog_reg, tog_s1_reg, tog_s2_reg};
			{fr_s1_reg, fr_s2_reg, fr_s3_reg}    <= {out_frame, fr_s1_reg, fr_s2_reg};
			{mu_s1_reg, mu_s2_reg}               <= {mute_in, mu_s1_reg};
		end
	end

	// link data is held for a whole input frame, so it is steady once the toggle lands
	wire in_ev  = tog_s2_reg ^ tog_s3_reg;
	wire out_ev = fr_s2_reg & ~fr_s3_reg;

	////////////////////////////////////////////////////////////////////////
	// state

	asrc_state_t state_reg;
	logic [8:0]  in_cnt_reg;
	logic [11:0] mute_cnt_reg;
	logic [15:0] cyc_reg;
	logic [23:0] per_reg;
	logic        fast_reg;
	logic [4:0]  calm_reg;
	logic [5:0]  win_reg;
	logic [9:0]  win_in_reg;
	logic [9:0]  ratio_reg;
	logic [16:0] recip_reg;
	logic [8:0]  ptr_reg;
	logic [26:0] rom_reg;
	logic [20:0] step_reg;
	logic signed [47:0] acc_l_reg;
	logic signed [47:0] acc_r_reg;
	logic [23:0] out_l_reg;
	logic [23:0] out_r_reg;
	logic        out_v_reg;
	logic        settle_reg;
	logic        oe_reg;

	logic [23:0] ram_l [`ASRC_RAM_DEPTH];
	logic [23:0] ram_r [`ASRC_RAM_DEPTH];

	////////////////////////////////////////////////////////////////////////
	// fifo write path

	wire        clearing = (state_reg == ST_CLEAR);
	wire [12:0] gain     = 13'({1'b0, `ASRC_MUTE_FULL} - {1'b0, mute_cnt_reg});
	wire [8:0]  wr_addr  = 9'(in_cnt_reg + `ASRC_WR_OFFSET);
	wire        ram_we   = clearing | in_ev;
	wire [8:0]  ram_wa   = clearing ? ptr_reg : wr_addr;
	wire [23:0] ram_wl   = clearing ? 24'h000000 : scale_in(lk_l_reg, gain, recip_reg);
	wire [23:0] ram_wr   = clearing ? 24'h000000 : scale_in(lk_r_reg, gain, recip_reg);

	always_ff @(posedge clk_sys) begin
		if (ram_we) begin
			ram_l[ram_wa] <= ram_wl;
			ram_r[ram_wa] <= ram_wr;
		end
	end

	wire mute_up   = mu_s2_reg & (mute_cnt_reg != `ASRC_MUTE_FULL);
	wire mute_down = ~mu_s2_reg & (mute_cnt_reg != 12'h000);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			in_cnt_reg   <= 9'h000;
			mute_cnt_reg <= `ASRC_MUTE_FULL;
		end else if (in_ev) begin
			in_cnt_reg <= 9'(in_cnt_reg + 9'h001);
			if (mute_up)
				mute_cnt_reg <= 12'(mute_cnt_reg + 12'h001);
			else if (mute_down)
				mute_cnt_reg <= 12'(mute_cnt_reg - 12'h001);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// servo: filtered input period in 1/256 clock units

	wire [23:0]        meas     = {16'(cyc_reg + 16'h0001), 8'h00};
	wire signed [24:0] err      = $signed({1'b0, meas}) - $signed({1'b0, per_reg});
	wire [24:0]        err_abs  = err[24] ? 25'(-err) : 25'(err);
	wire [4:0]         k_sh     = fast_reg ? `ASRC_K_FAST : `ASRC_K_SLOW;
	wire signed [24:0] per_sum  = $signed({1'b0, per_reg}) + (err >>> k_sh);
	wire [23:0]        per_next = (per_reg == 24'h000000) ? meas : per_sum[23:0];
	wire               calm     = err_abs < `ASRC_CALM_ERR;
	wire               jump     = err_abs > {5'h00, per_reg[23:4]};
	wire               settled  = calm & (calm_reg == `ASRC_CALM_LAST);

	// ratio window: input frames counted over 64 output frames
	wire        win_end   = out_ev & (win_reg == `ASRC_WIN_LAST);
	wire [9:0]  win_cnt   = 10'(win_in_reg + {9'h000, in_ev});
	wire [9:0]  cand      = (win_cnt < `ASRC_RATIO_ONE) ? `ASRC_RATIO_ONE :
		(win_cnt > `ASRC_RATIO_MAX) ? `ASRC_RATIO_MAX : win_cnt;
	wire [9:0]  rdiff     = (cand > ratio_reg) ? 10'(cand - ratio_reg) : 10'(ratio_reg - cand);
	wire        ratio_upd = win_end & (cand != ratio_reg) &
		((rdiff > `ASRC_HYST) | (cand == `ASRC_RATIO_ONE));

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cyc_reg  <= 16'h0000;
			per_reg  <= 24'h000000;
			fast_reg <= 1'b1;
			calm_reg <= 5'h00;
		end else begin
			if (in_ev) begin
				cyc_reg  <= 16'h0000;
				per_reg  <= per_next;
				calm_reg <= calm ? 5'(calm_reg + 5'h01) : 5'h00;
			end else if (cyc_reg != 16'hFFFF) begin
				cyc_reg <= 16'(cyc_reg + 16'h0001);
			end
			// a rate change on either side throws the loop back to fast
			if (ratio_upd | (in_ev & ~fast_reg & jump))
				fast_reg <= 1'b1;
			else if (in_ev & fast_reg & settled)
				fast_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			win_reg    <= 6'h00;
			win_in_reg <= 10'h000;
			ratio_reg  <= `ASRC_RATIO_ONE;
			recip_reg  <= `ASRC_RECIP_ONE;
		end else begin
			if (out_ev)
				win_reg <= 6'(win_reg + 6'h01);
			if (win_end)
				win_in_reg <= 10'h000;
			else if (in_ev & (win_in_reg != 10'h3FF))
				win_in_reg <= win_cnt;
			if (ratio_upd) begin
				ratio_reg <= cand;
				recip_reg <= 17'(`ASRC_RECIP_NUM / cand);
			end
		end
	end

	// phase of this output frame inside the current input period, 2^20 steps
	wire [43:0] frac_num  = {cyc_reg, 28'h0000000};
	wire [43:0] frac_q    = (per_reg == 24'h000000) ? 44'h0 : frac_num / {20'h00000, per_reg};
	wire [19:0] frac      = (frac_q > 44'(`ASRC_FRAC_MAX)) ? `ASRC_FRAC_MAX : frac_q[19:0];
	wire [36:0] frac_sc   = {17'h00000, frac} * {20'h00000, recip_reg};
	wire [19:0] rom_start = frac_sc[35:16];
	wire [20:0] rom_step  = {recip_reg, 4'h0};

	////////////////////////////////////////////////////////////////////////
	// convolution: one shared multiplier, left then right per tap

	wire signed [23:0] mac_a  = (state_reg == ST_LEFT) ? ram_l[ptr_reg] : ram_r[ptr_reg];
	wire signed [17:0] mac_c  = coef_at(rom_reg[25:0]);
	wire signed [47:0] mac_p  = mac_a * mac_c;
	wire [26:0]        rom_nx = 27'(rom_reg + {6'h00, step_reg});

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_CLEAR;
			ptr_reg   <= 9'h000;
			rom_reg   <= 27'h0000000;
			step_reg  <= `ASRC_STEP_ONE;
			acc_l_reg <= 48'sh0;
			acc_r_reg <= 48'sh0;
			out_l_reg <= 24'h000000;
			out_r_reg <= 24'h000000;
			out_v_reg <= 1'b0;
		end else begin
			out_v_reg <= 1'b0;
			case (state_reg)
				ST_CLEAR: begin
					ptr_reg <= 9'(ptr_reg + 9'h001);
					if (ptr_reg == `ASRC_RAM_LAST)
						state_reg <= ST_IDLE;
				end
				ST_IDLE: begin
					if (out_ev) begin
						ptr_reg   <= in_cnt_reg;
						rom_reg   <= {7'h00, rom_start};
						step_reg  <= rom_step;
						acc_l_reg <= 48'sh0;
						acc_r_reg <= 48'sh0;
						state_reg <= ST_LEFT;
					end
				end
				ST_LEFT: begin
					acc_l_reg <= acc_l_reg + mac_p;
					state_reg <= ST_RIGHT;
				end
				ST_RIGHT: begin
					acc_r_reg <= acc_r_reg + mac_p;
					ptr_reg   <= 9'(ptr_reg - 9'h001);
					rom_reg   <= rom_nx;
					state_reg <= rom_nx[26] ? ST_DONE : ST_LEFT;
				end
				ST_DONE: begin
					out_l_reg <= sat24(acc_l_reg);
					out_r_reg <= sat24(acc_r_reg);
					out_v_reg <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// settle flag from a flop; drives nothing while reset holds
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			settle_reg <= 1'b1;
			oe_reg     <= 1'b0;
		end else begin
			settle_reg <= fast_reg | clearing;
			oe_reg     <= 1'b1;
		end
	end

	assign out_left    = out_l_reg;
	assign out_right   = out_r_reg;
	assign out_valid   = out_v_reg;
	assign settle_mute = settle_reg;
	assign pins_oe     = oe_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	property p_settle_high;
		fast_reg |=> settle_reg;
	endproperty
	a_settle_high: assert property (p_settle_high) else $error("settle flag low in fast mode");

	property p_settle_drop;
		$fell(fast_reg) && !clearing |=> !settle_reg;
	endproperty
	a_settle_drop: assert property (p_settle_drop) else $error("settle flag late");

	property p_wr_offset;
		in_ev && !clearing |-> ram_wa == 9'(in_cnt_reg + 9'h010);
	endproperty
	a_wr_offset: assert property (p_wr_offset) else $error("write offset wrong");

	property p_step_one;
		state_reg == ST_IDLE && out_ev && ratio_reg == `ASRC_RATIO_ONE |=>
			step_reg == `ASRC_STEP_ONE;
	endproperty
	a_step_one: assert property (p_step_one) else $error("tap step not 2^20");

	property p_ptr_down;
		state_reg == ST_RIGHT |=> ptr_reg == 9'($past(ptr_reg) - 9'h001);
	endproperty
	a_ptr_down: assert property (p_ptr_down) else $error("RAM pointer not stepping down");

	property p_shared_mac;
		state_reg == ST_LEFT |=> state_reg == ST_RIGHT;
	endproperty
	a_shared_mac: assert property (p_shared_mac) else $error("channel order broken");

	property p_ratio_floor;
		ratio_reg >= `ASRC_RATIO_ONE && recip_reg <= `ASRC_RECIP_ONE;
	endproperty
	a_ratio_floor: assert property (p_ratio_floor) else $error("ratio below one");

	property p_hyst;
		win_end && cand != `ASRC_RATIO_ONE && rdiff <= `ASRC_HYST |=> $stable(ratio_reg);
	endproperty
	a_hyst: assert property (p_hyst) else $error("ratio moved inside hysteresis");

	property p_mute_step;
		in_ev && mu_s2_reg && mute_cnt_reg != `ASRC_MUTE_FULL |=>
			mute_cnt_reg == 12'($past(mute_cnt_reg) + 12'h001);
	endproperty
	a_mute_step: assert property (p_mute_step) else $error("mute counter not stepping");

	property p_done_out;
		state_reg == ST_DONE |=> out_v_reg ##1 !out_v_reg;
	endproperty
	a_done_out: assert property (p_done_out) else $error("output strobe wrong");

	property p_clear_flags;
		clearing |=> settle_reg && oe_reg;
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("init flags wrong");
endmodule

//--- bench/asrc_far_end.sv
`timescale 1ns/1ps
module asrc_far_end #(
	parameter int IN_GAP  = 12,
	parameter int OUT_GAP = 800
) (
	input  wire logic        clk_sys,
	input  wire logic        clk_link,
	input  wire logic        run,
	input  wire logic [23:0] level_left,
	input  wire logic [23:0] level_right,
	output logic             in_strobe,
	output logic      [23:0] in_left,
	output logic      [23:0] in_right,
	output logic             out_frame
);
	int in_cnt = 0;
	int out_cnt = 0;

	initial begin
		in_strobe = 1'b0;
		in_left = 24'h000000;
		in_right = 24'h000000;
		out_frame = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// source: one-cycle strobe, words held until the next strobe
	always @(posedge clk_link) begin
		#1;
		in_strobe = 1'b0;
		if (run) begin
			in_cnt = (in_cnt + 1) % IN_GAP;
			if (in_cnt == 0) begin
				in_strobe = 1'b1;
				in_left = level_left;
				in_right = level_right;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sink: square frame clock, steady period so the servo can settle
	always @(posedge clk_sys) begin
		#1;
		if (run) begin
			out_cnt = (out_cnt + 1) % OUT_GAP;
			out_frame = (out_cnt < OUT_GAP / 2);
		end
	end
endmodule

//--- bench/asrc_core_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module asrc_core_bench;
	localparam int IN_GAP  = 12;
	localparam int OUT_GAP = 800;
	// link periods of 125 ns against 4 ns master clocks
	localparam int TAPS_DEC = 64 * OUT_GAP * 4 / (IN_GAP * 125);

	logic        clk_sys = 1'b0;
	logic        clk_link = 1'b0;
	logic        arst_n = 1'b0;
	logic        mute_in = 1'b1;
	logic        run = 1'b0;
	logic [23:0] level_left = 24'h000000;
	logic [23:0] level_right = 24'h000000;
	logic        in_strobe;
	logic [23:0] in_left;
	logic [23:0] in_right;
	logic        out_frame;
	logic [23:0] out_left;
	logic [23:0] out_right;
	logic        out_valid;
	logic        settle_mute;
	logic        pins_oe;
	logic        frame_q = 1'b0;
	logic        valid_q = 1'b0;
	logic        quiet_seen = 1'b0;
	int          errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          frames = 0;
	int          results = 0;
	int          edge_q[$];

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	// offset start keeps the link phase unrelated to the master clock
	initial begin
		#7;
		forever #62.5 clk_link = ~clk_link;
	end

	asrc_core uut (
		.clk_sys     (clk_sys),
		.arst_n      (arst_n),
		.clk_link    (clk_link),
		.in_strobe   (in_strobe),
		.in_left     (in_left),
		.in_right    (in_right),
		.out_frame   (out_frame),
		.mute_in     (mute_in),
		.out_left    (out_left),
		.out_right   (out_right),
		.out_valid   (out_valid),
		.settle_mute (settle_mute),
		.pins_oe     (pins_oe)
	);

	asrc_far_end #(.IN_GAP(IN_GAP), .OUT_GAP(OUT_GAP)) far_end (
		.clk_sys     (clk_sys),
		.clk_link    (clk_link),
		.run         (run),
		.level_left  (level_left),
		.level_right (level_right),
		.in_strobe   (in_strobe),
		.in_left     (in_left),
		.in_right    (in_right),
		.out_frame   (out_frame)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// first 40 results run at ratio one, the tail at the measured decimation
	task automatic check_result();
		int lat;
		int taps;
		if (edge_q.size() == 0) begin
			`CHK(1'b0, 1'b1)
			return;
		end
		lat = cyc - edge_q.pop_front();
		results++;
		taps = (results <= 40) ? 64 : TAPS_DEC;
		// servo is still fast at start-up and again after the first ratio update
		if (results == 1 || results == 65) begin
			`CHK(settle_mute, 1'b1)
		end
		if (results <= 40 || results >= 95) begin
			`CHK(lat >= 2 * taps && lat <= 2 * taps + 10, 1'b1)
		end
		if (results <= 30) begin
			`CHK(out_left, 24'h000000)
			`CHK(out_right, 24'h000000)
		end else begin
			`CHK($signed(out_left) >= 0 && $signed(out_left) <= $signed(level_left), 1'b1)
			`CHK($signed(out_right) <= 0 && $signed(out_right) >= $signed(level_right), 1'b1)
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// model side: queue of frame edges, settled sampling on the falling edge
	always @(negedge clk_sys) begin
		cyc++;
		if (out_frame === 1'b1 && frame_q === 1'b0) begin
			edge_q.push_back(cyc);
			frames++;
		end
		frame_q = out_frame;
		if (valid_q === 1'b1) begin
			`CHK(out_valid, 1'b0)
		end
		valid_q = out_valid;
		if (run && settle_mute === 1'b0) begin
			quiet_seen = 1'b1;
		end
		if (out_valid === 1'b1) begin
			check_result();
		end
	end

	initial begin
		#400000;
		errors++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(36));
		level_left = {2'b01, 22'($urandom)};
		level_right = {2'b10, 22'($urandom)};
		// reset held 8 cycles, above the five-cycle minimum
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(pins_oe, 1'b0)
		`CHK(out_valid, 1'b0)
		`CHK(out_left, 24'h000000)
		`CHK(settle_mute, 1'b1)
		@(posedge clk_sys);
		#1 arst_n = 1'b1;
		@(negedge clk_sys);
		@(negedge clk_sys);
		`CHK(pins_oe, 1'b1)
		`CHK(settle_mute, 1'b1)
		// frame edges before the clear ends would be dropped
		repeat (600) @(posedge clk_sys);
		#1 run = 1'b1;
		while (results < 30) @(posedge clk_sys);
		#1 mute_in = 1'b0;
		while (results < 100) @(posedge clk_sys);
		// mute again so the counter climbs back toward full attenuation
		#1 mute_in = 1'b1;
		while (results < 110) @(posedge clk_sys);
		`CHK(quiet_seen, 1'b1)
		`CHK(edge_q.size() <= 1, 1'b1)
		`CHK(out_left != 24'h000000, 1'b1)
		summarize();
	end
endmodule
